// file: hw/scbu_defines.svh
// Constants for the signed compare branch unit.
// What this block does
// - A greater-than branch is taken only when the first source is above zero, else PC plus four.
// - A less-or-equal branch is taken only when the first source is at most zero, else PC plus four.
// - A less-than branch is taken only when the first source is below zero, else PC plus four.
// - A taken register-offset branch loads the branch address plus the offset source.
// - A taken immediate branch loads the branch address plus the extended literal.
// - Without a prefix the 16-bit literal is sign-extended to 32 bits.
// - A directly preceding upper-half prefix supplies the upper 16 bits of the operand.
// - The delayed variant sets the slot flag and the plain variant clears it.
// - With the slot flag set, the following instruction completes before the target runs.
// - With the slot flag clear, a taken branch squashes the following instruction.
// - Register branches cost one cycle not taken, two taken delayed, three taken plain.
// - Immediate branches cost one not taken or predicted, two taken delayed, else three.
// - Interrupts and hardware breaks wait until a delayed branch and its slot complete.
`ifndef SCBU_DEFINES_SVH
`define SCBU_DEFINES_SVH
`define SCBU_PC_STEP    32'h0000_0004
`define SCBU_LIT_W      16
`define SCBU_COST_SKIP  2'h1
`define SCBU_COST_SLOT  2'h2
`define SCBU_COST_FULL  2'h3
`endif

// file: hw/scbu_operand.sv
// Offset operand former: register offset, sign extension or prefix upper half.
`include "scbu_defines.svh"
module scbu_operand
  import scbu_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_prefix_valid,
  input  wire logic [15:0] i_prefix_upper,
  input  wire logic        i_issue,
  input  wire logic        i_imm_form,
  input  wire logic [15:0] i_literal,
  input  wire logic [31:0] i_offset_source,
  output logic      [31:0] o_offset
);
  logic        held;
  logic [15:0] held_upper;

  // The prefix holds only for the instruction right after it, so any issue clears it.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      held       <= 1'b0;
      held_upper <= 16'h0000;
    end else if (i_ce) begin
      if (i_prefix_valid) begin
        held       <= 1'b1;
        held_upper <= i_prefix_upper;
      end else if (i_issue) begin
        held <= 1'b0;
      end
    end
  end

  // Operand select; register form uses the offset source directly.
  always_comb begin
    if (!i_imm_form) begin
      o_offset = i_offset_source;
    end else if (held) begin
      o_offset = {held_upper, i_literal};
    end else begin
      o_offset = {{(32-`SCBU_LIT_W){i_literal[15]}}, i_literal};
    end
  end

  // The prefix half lives exactly until the next issue, so a stale half can never
  // leak into a later immediate branch.
  prefix_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_prefix_valid |=> held && held_upper == $past(i_prefix_upper))
    else $error("Prefix half not kept for the next issue.");
  prefix_drop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_issue && !i_prefix_valid |=> !held)
    else $error("Prefix half outlived its instruction.");
endmodule

// file: hw/scbu_pkg.sv
// Types shared by the signed compare branch unit.
package scbu_pkg;
  // Condition families that this unit resolves.
  typedef enum logic [1:0] {
    SCBU_GT = 2'b00,
    SCBU_LE = 2'b01,
    SCBU_LT = 2'b10,
    SCBU_NONE = 2'b11
  } scbu_cond_e;
  // Sequencing after a branch.
  typedef enum logic [1:0] {
    SCBU_IDLE    = 2'b00,
    SCBU_SLOT    = 2'b01,
    SCBU_BUBBLE  = 2'b10
  } scbu_state_e;
endpackage

// file: hw/scbu_top.sv
// Branch resolution for the signed compare-with-zero conditional branches.
`include "scbu_defines.svh"
module scbu_top
  import scbu_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_issue,
  input  wire scbu_cond_e  i_cond,
  input  wire logic        i_imm_form,
  input  wire logic        i_delay,
  input  wire logic        i_predicted,
  input  wire logic        i_prefix_valid,
  input  wire logic [15:0] i_prefix_upper,
  input  wire logic [31:0] i_pc,
  input  wire logic [31:0] i_first_source,
  input  wire logic [31:0] i_offset_source,
  input  wire logic [15:0] i_literal,
  input  wire logic        i_slot_done,
  output logic             o_done,
  output logic             o_taken,
  output logic [31:0]      o_next_pc,
  output logic             o_slot_flag,
  output logic [1:0]       o_cost,
  output logic             o_squash_next,
  output logic             o_irq_hold
);
  logic [31:0] offset;
  logic        is_branch;
  logic        cond_true;
  logic        slot_open;
  logic        bubble;
  // Sequencing state after a branch: idle, waiting on a delay slot, or squashing.
  scbu_state_e seq_state;
  scbu_state_e next_seq_state;

  scbu_operand u_operand (
    .i_core_clk      (i_core_clk),
    .i_rst           (i_rst),
    .i_ce            (i_ce),
    .i_prefix_valid  (i_prefix_valid),
    .i_prefix_upper  (i_prefix_upper),
    .i_issue         (i_issue),
    .i_imm_form      (i_imm_form),
    .i_literal       (i_literal),
    .i_offset_source (i_offset_source),
    .o_offset        (offset)
  );

  assign is_branch = i_issue && (i_cond != SCBU_NONE);

  // Signed test against zero; the sign bit and a zero check are all it takes.
  always_comb begin
    case (i_cond)
      SCBU_GT: cond_true = !i_first_source[31] && (i_first_source != 32'h0000_0000);
      SCBU_LE: cond_true = i_first_source[31] || (i_first_source == 32'h0000_0000);
      SCBU_LT: cond_true = i_first_source[31];
      default: cond_true = 1'b0;
    endcase
  end

  // Result registers: done, taken, next program counter, slot flag and cost leave this unit.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_done      <= 1'b0;
      o_taken     <= 1'b0;
      o_next_pc   <= 32'h0000_0000;
      o_slot_flag <= 1'b0;
      o_cost      <= 2'h0;
    end else if (i_ce) begin
      o_done <= is_branch;
      if (is_branch) begin
        o_taken     <= cond_true;
        o_slot_flag <= i_delay;
        // Taken adds the offset to the branch's own address.
        o_next_pc <= cond_true ? i_pc + offset : i_pc + `SCBU_PC_STEP;
        if (!cond_true) begin
          o_cost <= `SCBU_COST_SKIP;
        end else if (i_imm_form && i_predicted) begin
          o_cost <= `SCBU_COST_SKIP;
        end else if (i_delay) begin
          o_cost <= `SCBU_COST_SLOT;
        end else begin
          o_cost <= `SCBU_COST_FULL;
        end
      end
    end
  end

  // Decision checks. The outcome is worked out again as a plain signed compare, so a
  // slip in the sign-bit shortcut above cannot hide behind its own expression.
  pc_fallthru_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && !cond_true |=> o_next_pc == $past(i_pc) + `SCBU_PC_STEP)
    else $error("Not-taken branch did not advance by four.");
  gt_take_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && i_cond == SCBU_GT |=> o_taken == ($signed($past(i_first_source)) > 0))
    else $error("Greater-than decision wrong.");
  le_take_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && i_cond == SCBU_LE |=> o_taken == ($signed($past(i_first_source)) <= 0))
    else $error("Less-or-equal decision wrong.");
  lt_take_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && i_cond == SCBU_LT |=> o_taken == ($signed($past(i_first_source)) < 0))
    else $error("Less-than decision wrong.");

  // Target checks: the branch's own address plus the chosen offset, held until replaced.
  reg_target_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && cond_true && !i_imm_form
    |=> o_next_pc == $past(i_pc) + $past(i_offset_source))
    else $error("Register target wrong.");
  imm_target_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && cond_true && i_imm_form
    |=> o_next_pc == $past(i_pc) + $past(offset))
    else $error("Immediate target wrong.");
  slot_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch |=> o_slot_flag == $past(i_delay))
    else $error("Slot flag does not follow variant.");
  data_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !is_branch |=> $stable(o_taken) && $stable(o_next_pc) && $stable(o_slot_flag))
    else $error("Branch result changed without a branch.");

  // Cost checks, one for each row of the cost table.
  cost_plain_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && cond_true && !i_delay && !i_imm_form
    |=> o_cost == 2'h3 && o_squash_next)
    else $error("Plain taken cost or squash wrong.");
  imm_pred_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && i_imm_form && i_predicted |=> o_cost == 2'h1)
    else $error("Predicted immediate branch cost wrong.");
  skip_cost_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && !cond_true |=> o_cost == 2'h1 && !o_squash_next)
    else $error("Not-taken branch cost wrong.");
  slot_cost_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && cond_true && i_delay && !(i_imm_form && i_predicted)
    |=> o_cost == 2'h2)
    else $error("Delayed taken branch cost wrong.");
  imm_miss_cost_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && cond_true && !i_delay && i_imm_form && !i_predicted
    |=> o_cost == 2'h3 && o_squash_next)
    else $error("Unpredicted immediate branch cost wrong.");

  // Handshake checks: one done pulse per branch, and done, next PC, cost and state hold while disabled.
  done_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce |=> o_done == $past(is_branch))
    else $error("Done pulse does not follow the branch issue.");
  ce_freeze_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_ce |=> $stable(o_done) && $stable(o_next_pc) && $stable(o_cost)
    && $stable(seq_state))
    else $error("State moved while the enable was low.");

  // Delay slot tracking: the slot instruction must retire before the target, and
  // interrupts wait for it; a plain taken branch drops the sequential instruction.
  // A delayed branch wins over a slot completion in the same cycle, so a fresh slot
  // is never lost to the end of the previous one.
  always_comb begin
    next_seq_state = seq_state;
    case (seq_state)
      SCBU_IDLE, SCBU_BUBBLE: begin
        if (is_branch && i_delay) begin
          next_seq_state = SCBU_SLOT;
        end else if (is_branch && cond_true) begin
          next_seq_state = SCBU_BUBBLE;
        end else begin
          next_seq_state = SCBU_IDLE;
        end
      end
      SCBU_SLOT: begin
        // Limitation: a plain branch issued before the slot retires, which the stream
        // must never do, keeps the interrupt hold but loses its squash.
        if (is_branch && i_delay) begin
          next_seq_state = SCBU_SLOT;
        end else if (i_slot_done && is_branch && cond_true) begin
          next_seq_state = SCBU_BUBBLE;
        end else if (i_slot_done) begin
          next_seq_state = SCBU_IDLE;
        end else begin
          next_seq_state = SCBU_SLOT;
        end
      end
      default: begin
        next_seq_state = SCBU_IDLE;
      end
    endcase
  end

  // Sequencing state register; it freezes with everything else while disabled.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      seq_state <= SCBU_IDLE;
    end else if (i_ce) begin
      seq_state <= next_seq_state;
    end
  end

  // Squash is read straight off the state; hold is the slot state or a delayed branch at issue.
  assign slot_open = (seq_state == SCBU_SLOT);
  assign bubble    = (seq_state == SCBU_BUBBLE);

  // The stream never puts a branch in the slot, so a pending slot is never renewed.
  assign o_irq_hold    = slot_open || (is_branch && i_delay);
  assign o_squash_next = bubble;

  // Sequencing checks.
  // Unbounded slot wait is not checked here; the pipeline guarantees retirement.
  irq_slot_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && i_delay ##1 !i_slot_done |=> o_irq_hold)
    else $error("Interrupt released before slot done.");
  slot_stay_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    slot_open && !i_slot_done |=> o_irq_hold)
    else $error("Interrupt hold dropped while the slot is pending.");
  irq_release_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && slot_open && i_slot_done && !is_branch
    |=> !o_irq_hold || (is_branch && i_delay))
    else $error("Interrupt hold kept after the slot completed.");
  slot_enter_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && i_delay |=> slot_open)
    else $error("Delayed branch did not open a slot.");
  slot_seq_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_branch && i_delay |=> !o_squash_next)
    else $error("Delayed branch squashed its slot.");
  squash_only_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !(is_branch && cond_true && !i_delay) |=> !o_squash_next)
    else $error("Squash without a plain taken branch.");
  squash_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && o_squash_next && !is_branch |=> !o_squash_next)
    else $error("Squash lasted more than one instruction.");
  state_legal_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    seq_state inside {SCBU_IDLE, SCBU_SLOT, SCBU_BUBBLE})
    else $error("Sequencing state left its legal set.");
endmodule

// file: tb/scbu_fetch_model.sv
// Fetch-stage model that completes the delay-slot instruction after a set wait.
module scbu_fetch_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_done,
  input  wire logic       i_slot_flag,
  input  wire logic [3:0] i_slot_cycles,
  output logic            o_slot_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt = 4'h0;
  // The slot always holds a plain instruction, never a prefix, branch or break.
  // A long wait shows that the block keeps its hold for as long as the slot takes.
  always @(posedge i_core_clk) begin
    if (i_done && i_slot_flag) begin
      wait_cnt <= i_slot_cycles;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
  assign o_slot_done = (wait_cnt == 4'h1);
endmodule

// file: tb/signed_compare_branch_unit_bench.sv
// Self-checking bench for the signed compare branch unit.
module signed_compare_branch_unit_bench;
  import scbu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, issue = 1'b0, imm_form = 1'b0, delay = 1'b0;
  logic        predicted = 1'b0, pfx_valid = 1'b0, ce = 1'b1;
  scbu_cond_e  cond = SCBU_NONE;
  logic [15:0] pfx_upper = 16'h0, literal = 16'h0;
  logic [31:0] pc = 32'h0, first_src = 32'h0, offset_src = 32'h0, next_pc;
  logic [3:0]  slot_cycles = 4'h1;
  logic        slot_done, done, taken, slot_flag, squash, irq_hold;
  logic [1:0]  cost;
  int          bad_count = 0, num_checks = 0;

  scbu_top u_dut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_issue(issue),
    .i_cond(cond), .i_imm_form(imm_form), .i_delay(delay), .i_predicted(predicted),
    .i_prefix_valid(pfx_valid), .i_prefix_upper(pfx_upper), .i_pc(pc),
    .i_first_source(first_src), .i_offset_source(offset_src), .i_literal(literal),
    .i_slot_done(slot_done), .o_done(done), .o_taken(taken), .o_next_pc(next_pc),
    .o_slot_flag(slot_flag), .o_cost(cost), .o_squash_next(squash), .o_irq_hold(irq_hold));
  scbu_fetch_model u_fetch (.i_core_clk(clk), .i_done(done), .i_slot_flag(slot_flag),
    .i_slot_cycles(slot_cycles), .o_slot_done(slot_done));

  // Free-running core clock at 50 MHz.
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One branch; the literal and prefix half come from b so each unit stays 16 bits wide.
  task automatic branch(input scbu_cond_e c, input logic im, dl, pr, pf,
                        input logic [31:0] a, b);
    logic        tk;
    logic [31:0] off, p;
    int          n;
    tk = (c == SCBU_GT) ? ($signed(a) > 0) : (c == SCBU_LE) ? ($signed(a) <= 0) : ($signed(a) < 0);
    off = (!im || pf) ? b : {{16{b[15]}}, b[15:0]};
    p = pc + 32'h100;
    n = 0;
    if (pf) begin
      @(posedge clk);
      pfx_valid <= 1'b1;
      pfx_upper <= b[31:16];
    end
    @(posedge clk);
    pfx_valid <= 1'b0;
    {issue, imm_form, delay, predicted} <= {1'b1, im, dl, pr};
    cond <= c;
    {first_src, offset_src, literal, pc} <= {a, b, b[15:0], p};
    @(posedge clk);
    issue <= 1'b0;
    #1;
    chk("done", 32'h1, done);
    chk("taken", tk, taken);
    chk("next_pc", tk ? p + off : p + 32'h4, next_pc);
    chk("slot_flag", dl, slot_flag);
    chk("cost", (!tk || (im && pr)) ? 1 : dl ? 2 : 3, cost);
    chk("squash", tk && !dl, squash);
    chk("irq_hold", dl, irq_hold);
    if (dl) begin
      while (slot_done !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("irq_hold_slot", 32'h1, irq_hold);
      @(posedge clk);
      #1;
      chk("irq_hold_after", 32'h0, irq_hold);
    end
  endtask

  // Every family against the sign boundaries, register-offset form.
  task automatic run_sign_table();
    scbu_cond_e  cs[3] = '{SCBU_GT, SCBU_LE, SCBU_LT};
    logic [31:0] vs[5] = '{32'h8000_0000, 32'hffff_ffff, 32'h0, 32'h1, 32'h7fff_ffff};
    foreach (cs[i]) begin
      foreach (vs[j]) begin
        branch(cs[i], 1'b0, 1'b0, 1'b0, 1'b0, vs[j], 32'h40);
      end
    end
  endtask

  // Delayed variants with a prompt and a slow slot, taken and not taken.
  task automatic run_delay();
    branch(SCBU_GT, 1'b0, 1'b1, 1'b0, 1'b0, 32'h5, 32'h8);
    slot_cycles <= 4'h5;
    branch(SCBU_LT, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 32'h10);
    branch(SCBU_GT, 1'b1, 1'b1, 1'b0, 1'b0, 32'h1, 32'hfffc);
  endtask

  // Immediate forms: negative literal, predicted branch, prefixed upper half.
  task automatic run_immediate();
    branch(SCBU_LT, 1'b1, 1'b0, 1'b0, 1'b0, 32'hffff_fff0, 32'h1234_8000);
    branch(SCBU_LE, 1'b1, 1'b0, 1'b1, 1'b0, 32'h0, 32'h10);
    branch(SCBU_GT, 1'b1, 1'b0, 1'b0, 1'b1, 32'h2, 32'h1234_8000);
  endtask

  // A branch offered with the enable low must leave done, next PC, taken and squash as they were.
  task automatic run_hold();
    logic [31:0] was_pc;
    logic        was_taken;
    was_pc = next_pc;
    was_taken = taken;
    @(posedge clk);
    ce <= 1'b0;
    {issue, imm_form, delay, predicted} <= {1'b1, 1'b0, 1'b0, 1'b0};
    cond <= SCBU_LT;
    {first_src, offset_src, pc} <= {32'h1, 32'h80, pc + 32'h100};
    @(posedge clk);
    issue <= 1'b0;
    ce <= 1'b1;
    #1;
    chk("done_frozen", 32'h0, done);
    chk("next_pc_frozen", was_pc, next_pc);
    chk("taken_frozen", was_taken, taken);
    chk("squash_frozen", 32'h0, squash);
  endtask

  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence after a 12-cycle reset.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    run_sign_table();
    run_delay();
    run_immediate();
    run_hold();
    finish_test();
  end

  // Watchdog well beyond the fewer than a hundred cycles the sequence needs.
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule
